//--- src/sram_host_ctrl.sv
// Host controller that drives a 16-bit two-lane asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl
	import sram_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire req_type req,
	output logic req_ready,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic wr_done,
	input wire logic retain_req,
	output logic retain_ack,
	output pins_type pins,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe
);
	typedef struct packed {
		state_type st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] lanes;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic wdone;
		logic drive;
		pins_type p;
	} ctl_type;

	// All controls inactive; address value is a don't-care while deselected
	localparam pins_type PINS_IDLE = '{
		cs_n: 1'b1,
		oe_n: 1'b1,
		we_n: 1'b1,
		low_lane_select_n: 1'b1,
		high_lane_select_n: 1'b1,
		addr: '0
	};

	ctl_type ctl_r;
	ctl_type ctl_nxt;

	always_comb begin
		ctl_nxt = ctl_r;
		ctl_nxt.rvalid = 1'b0;
		ctl_nxt.wdone = 1'b0;
		case (ctl_r.st)
			ST_IDLE: begin
				ctl_nxt.p.cs_n = 1'b1;
				ctl_nxt.p.oe_n = 1'b1;
				ctl_nxt.p.we_n = 1'b1;
				ctl_nxt.drive = 1'b0;
				if (retain_req) begin
					ctl_nxt.st = ST_RETAIN;
				end else if (req.valid) begin
					ctl_nxt.p.addr = req.addr;
					ctl_nxt.lanes = req.lanes;
					ctl_nxt.wdata = req.wdata;
					ctl_nxt.p.cs_n = 1'b0;
					ctl_nxt.p.low_lane_select_n = ~req.lanes[0];
					ctl_nxt.p.high_lane_select_n = ~req.lanes[1];
					if (req.write) begin
						// Output enable stays high on writes
						ctl_nxt.st = ST_WR_SETUP;
					end else begin
						ctl_nxt.p.oe_n = 1'b0;
						ctl_nxt.st = ST_RD;
						ctl_nxt.cnt = CNT_W'(RD_CYC);
					end
				end
			end
			ST_RD: begin
				if (ctl_r.cnt > CNT_W'(1)) begin
					ctl_nxt.cnt = ctl_r.cnt - CNT_W'(1);
				end else begin
					ctl_nxt.rdata = dq_in;
					ctl_nxt.rvalid = 1'b1;
					ctl_nxt.p = PINS_IDLE;
					ctl_nxt.p.addr = ctl_r.p.addr;
					ctl_nxt.st = ST_TURN;
					ctl_nxt.cnt = CNT_W'(TURN_CYC);
				end
			end
			ST_WR_SETUP: begin
				ctl_nxt.p.we_n = 1'b0;
				ctl_nxt.drive = 1'b1;
				ctl_nxt.st = ST_WR;
				ctl_nxt.cnt = CNT_W'(WR_CYC);
			end
			ST_WR: begin
				if (ctl_r.cnt > CNT_W'(1)) begin
					ctl_nxt.cnt = ctl_r.cnt - CNT_W'(1);
				end else begin
					ctl_nxt.p.we_n = 1'b1;
					ctl_nxt.wdone = 1'b1;
					ctl_nxt.st = ST_TURN;
					ctl_nxt.cnt = CNT_W'(TURN_CYC);
				end
			end
			ST_TURN: begin
				ctl_nxt.p.cs_n = 1'b1;
				ctl_nxt.p.low_lane_select_n = 1'b1;
				ctl_nxt.p.high_lane_select_n = 1'b1;
				// Zero data hold lets drive stop with strobe high
				ctl_nxt.drive = 1'b0;
				if (ctl_r.cnt > CNT_W'(1)) begin
					ctl_nxt.cnt = ctl_r.cnt - CNT_W'(1);
				end else begin
					ctl_nxt.st = ST_IDLE;
				end
			end
			ST_RETAIN: begin
				if (!retain_req) begin
					ctl_nxt.st = ST_RECOVER;
					ctl_nxt.cnt = CNT_W'(REC_CYC);
				end
			end
			ST_RECOVER: begin
				if (ctl_r.cnt > CNT_W'(1)) begin
					ctl_nxt.cnt = ctl_r.cnt - CNT_W'(1);
				end else begin
					ctl_nxt.st = ST_IDLE;
				end
			end
			default: begin
				ctl_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= '{
				st: ST_IDLE,
				cnt: '0,
				lanes: '0,
				wdata: '0,
				rdata: '0,
				rvalid: 1'b0,
				wdone: 1'b0,
				drive: 1'b0,
				p: PINS_IDLE
			};
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// Cycle spacing: idle state plus turnaround exceed minimum cycle
	assign req_ready = (ctl_r.st == ST_IDLE) && !retain_req;
	assign rd_data = ctl_r.rdata;
	assign rd_valid = ctl_r.rvalid;
	assign wr_done = ctl_r.wdone;
	assign retain_ack = (ctl_r.st == ST_RETAIN);
	assign pins = ctl_r.p;
	assign dq_out = ctl_r.wdata;

	genvar g;
	generate
		for (g = 0; g < DATA_W; g++) begin : g_oe
			assign dq_oe[g] = ctl_r.drive & ctl_r.lanes[g / 8];
		end
	endgenerate
endmodule // sram_host_ctrl
`default_nettype wire

//--- common/sram_host_pkg.sv
// Package: constants and carriers for the asynchronous static memory host controller
// Behaviour
// - Write opens when select, strobe, a lane low; first rising ends it.
// - Host holds write data valid 8 ns before write end, until that edge.
// - Lane selects low 9 ns before write end; strobe pulse at least 10 ns.
// - Strobe write with output enable low: pulse at least 8 plus 7 ns.
// - Host leaves data lines undriven while memory may still drive them.
// - Host keeps write strobe high through every read.
// - Address valid no later than chip select falling for reads.
// - After retention exit wait 15 ns before any access.
package sram_host_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 20;
	// Times in ns as printed
	localparam int T_RC_NS = 15;
	localparam int T_AA_NS = 15;
	localparam int T_SD_NS = 8;
	localparam int T_BW_NS = 9;
	localparam int T_PWE_NS = 10;
	localparam int T_HZWE_NS = 7;
	localparam int T_HZ_NS = 7;
	localparam int T_R_NS = 15;
	// Cycle counts; least times round up
	localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC = (T_SD_NS + T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REC_CYC = (T_R_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_MIN = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR, ST_TURN, ST_RETAIN, ST_RECOVER
	} state_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] lanes;
	} req_type;

	typedef struct packed {
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic low_lane_select_n;
		logic high_lane_select_n;
		logic [ADDR_W-1:0] addr;
	} pins_type;
endpackage : sram_host_pkg

//--- bench/mem_model.sv
// Two-lane static memory model
`timescale 1ns/1ps
`default_nettype none
module mem_model
	import sram_host_pkg::*;
(
	input wire pins_type pins,
	input wire logic [DATA_W-1:0] wd,
	input wire logic [DATA_W-1:0] oe,
	output logic [DATA_W-1:0] rd
);
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] d;
	logic [1:0] on;
	// Drives only in a selected read
	assign on = (!pins.cs_n && !pins.oe_n && pins.we_n) ?
		~{pins.high_lane_select_n, pins.low_lane_select_n} : 2'b00;
	assign d = mem[pins.addr[7:0]];
	assign rd = {on[1] ? d[15:8] : ~d[15:8], on[0] ? d[7:0] : ~d[7:0]};
	// Strobe rise ends write; undriven lanes land inverted
	always @(posedge pins.we_n) begin
		if (!pins.cs_n && !pins.high_lane_select_n)
			mem[pins.addr[7:0]][15:8] <= oe[8] ? wd[15:8] : ~wd[15:8];
		if (!pins.cs_n && !pins.low_lane_select_n)
			mem[pins.addr[7:0]][7:0] <= oe[0] ? wd[7:0] : ~wd[7:0];
	end
endmodule // mem_model
`default_nettype wire

//--- bench/sram_host_ctrl_assertions.sv
// Port checks for the host controller
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_chk
	import sram_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire req_type req,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic wr_done,
	input wire logic retain_ack,
	input wire pins_type pins,
	input wire logic [DATA_W-1:0] dq_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_rd; req.valid && req_ready && !req.write |-> ##2 rd_valid; endproperty
	a_rd: assert property (p_rd) else $error("read late");
	property p_wr; req.valid && req_ready && req.write |-> ##3 wr_done; endproperty
	a_wr: assert property (p_wr) else $error("write late");
	property p_rdwe; !pins.oe_n |-> pins.we_n; endproperty
	a_rdwe: assert property (p_rdwe) else $error("strobe in read");
	property p_oe; dq_oe != '0 |-> pins.oe_n; endproperty
	a_oe: assert property (p_oe) else $error("contention");
	property p_setup; $fell(pins.we_n) |-> !$past(pins.cs_n) && !pins.cs_n; endproperty
	a_setup: assert property (p_setup) else $error("no setup");
	property p_lane;
		!pins.we_n |-> $stable(pins.low_lane_select_n) && $stable(pins.high_lane_select_n);
	endproperty
	a_lane: assert property (p_lane) else $error("lane moved in write");
	property p_pulse; $fell(pins.we_n) |=> $rose(pins.we_n); endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	// Lanes with no select must stay undriven, so the mask is exact
	property p_data;
		$rose(pins.we_n) |-> $stable(dq_oe) &&
			dq_oe == {{8{!pins.high_lane_select_n}}, {8{!pins.low_lane_select_n}}};
	endproperty
	a_data: assert property (p_data) else $error("data hold");
	property p_ret; retain_ack |-> pins.cs_n; endproperty
	a_ret: assert property (p_ret) else $error("retention");
	property p_rec; $fell(retain_ack) |-> !req_ready && pins.cs_n; endproperty
	a_rec: assert property (p_rec) else $error("no recovery");
	c_rd: cover property (rd_valid);
	c_wr: cover property (wr_done);
	c_ret: cover property (retain_ack);
endmodule // sram_host_ctrl_chk
bind sram_host_ctrl sram_host_ctrl_chk i_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.req(req),
	.req_ready(req_ready),
	.rd_valid(rd_valid),
	.wr_done(wr_done),
	.retain_ack(retain_ack),
	.pins(pins),
	.dq_oe(dq_oe)
);
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module tb import sram_host_pkg::*;;
	logic ref_clk = 0, rst_n = 0, retain_req = 0;
	req_type req = '0;
	pins_type pins;
	logic [DATA_W-1:0] rd_data, dq_in, dq_out, dq_oe, sh [0:255];
	logic req_ready, rd_valid, wr_done, retain_ack;
	int fails = 0, cmp_count = 0;
	always #10 ref_clk = ~ref_clk;
	sram_host_ctrl i_dut (.ref_clk, .rst_n, .req, .req_ready, .rd_data, .rd_valid, .wr_done,
		.retain_req, .retain_ack, .pins, .dq_in, .dq_out, .dq_oe);
	mem_model i_mem (.pins(pins), .wd(dq_out), .oe(dq_oe), .rd(dq_in));
	task automatic cmp(input logic [DATA_W-1:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: %h vs %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [1:0] ln, input logic [7:0] a,
		input logic [15:0] d);
		logic [15:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		while (req_ready !== 1'b1) @(negedge ref_clk);
		req = '{1'b1, w, {8'h00, a}, d, ln};
		@(negedge ref_clk);
		req.valid = 1'b0;
		// Pulse stands one cycle: one edge after the take for reads, two for writes
		repeat (w ? 2 : 1) @(negedge ref_clk);
		cmp(16'(w ? wr_done : rd_valid), 16'h0001);
		if (w) sh[a] = (sh[a] & ~m) | (d & m);
		else cmp(rd_data & m, sh[a] & m);
	endtask
	task automatic t_lanes;
		xfer(1'b1, 2'b11, 8'h5A, 16'h1234);
		xfer(1'b1, 2'b11, 8'hA5, 16'h0F0F);
		xfer(1'b1, 2'b01, 8'h5A, 16'hABCD);
		xfer(1'b1, 2'b10, 8'h5A, 16'h9E00);
		xfer(1'b1, 2'b00, 8'h5A, 16'hFFFF);
		for (int i = 0; i < 4; i++) xfer(1'b0, i[1:0], 8'h5A, 16'h0000);
	endtask
	task automatic t_retain;
		retain_req = 1'b1;
		req = '{1'b1, 1'b0, 16'h00A5, 16'h0000, 2'b11};
		repeat (4) @(negedge ref_clk);
		cmp(16'({retain_ack, req_ready, pins.cs_n}), 16'h0005);
		req.valid = 1'b0;
		retain_req = 1'b0;
		@(negedge ref_clk);
		cmp(16'({retain_ack, req_ready, pins.cs_n}), 16'h0001);
		xfer(1'b0, 2'b11, 8'hA5, 16'h0000);
	endtask
	initial begin
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		t_lanes;
		t_retain;
		end_sim;
	end
	// Run needs about 45 cycles
	initial begin
		#20000;
		fails++;
		end_sim;
	end
endmodule // tb
`default_nettype wire
